// *** cgen_clock_gen.sv ***
// system clock generator: source gating, pin modes and cpu clock
`timescale 1ns/1ps
module cgen_clock_gen #(
  parameter int DIV_CNT_W = 4
) (
  input  wire logic        CORE_CLK_I,
  input  wire logic        RSTN_I,
  input  wire logic        CE_I,
  // cpu memory access
  input  wire logic [15:0] ADDR_I,
  input  wire logic        WR_I,
  input  wire logic [7:0]  WDATA_I,
  input  wire logic        BIT_WR_I,
  input  wire logic [2:0]  BIT_SEL_I,
  input  wire logic        BIT_VAL_I,
  input  wire logic        RD_I,
  output logic      [7:0]  RDATA_O,
  // bits of the neighbouring control registers
  input  wire logic        STOP_MODE_I,
  input  wire logic        MAIN_OSC_STOP_I,
  input  wire logic        HS_INT_OSC_STOP_I,
  input  wire logic        LS_INT_OSC_STOP_I,
  input  wire logic        LS_SW_STOP_ALLOWED_I,
  input  wire logic        HS_CLOCK_ENABLE_SELECT_I,
  input  wire logic        MAIN_CLOCK_SOURCE_SELECT_I,
  input  wire logic        TIMER_USES_LS_I,
  input  wire logic        DISPLAY_USES_LS_I,
  // raw source ticks, one cycle each
  input  wire logic        CRYSTAL_TICK_I,
  input  wire logic        EXT_CLK_TICK_I,
  input  wire logic        HIGH_SPEED_INTERNAL_TICK_I,
  input  wire logic        SUB_CRYSTAL_TICK_I,
  input  wire logic        LOW_SPEED_INTERNAL_TICK_I,
  // oscillator enables and pin modes
  output logic             MAIN_OSC_EN_O,
  output logic             EXT_CLK_EN_O,
  output logic             HS_INT_OSC_EN_O,
  output logic             SUB_OSC_EN_O,
  output logic             LS_INT_OSC_EN_O,
  output logic             CRYSTAL_IN_PIN_PORT_O,
  output logic             CRYSTAL_OUT_PIN_PORT_O,
  output logic             SUB_CRYSTAL_PINS_PORT_O,
  // derived clocks as one-cycle ticks, and CPU_ON_SUB_O as a level
  output logic             MAIN_TICK_O,
  output logic             PERIPH_TICK_O,
  output logic             CPU_TICK_O,
  output logic             MIN_INSN_TICK_O,
  output logic             CPU_ON_SUB_O,
  output logic             WDT_TICK_O,
  output logic             TIMER_LS_TICK_O,
  output logic             DISPLAY_LS_TICK_O
);
  import cgen_pkg::*;

  // ---------------------------------------------------------------
  // register write decode
  // ---------------------------------------------------------------
  logic [7:0] pin_mode_ff;
  logic [7:0] nxt_pin_mode;
  logic       cpu_src_sub_ff;
  logic [2:0] cpu_div_ff;
  logic [7:0] cpu_ctrl_wr;
  logic       hit_pin;
  logic       hit_cpu;
  logic       on_sub_ff;

  assign hit_pin = (ADDR_I == PIN_MODE_ADDR);
  assign hit_cpu = (ADDR_I == CPU_CLK_CTRL_ADDR);

  // current register image merged with a byte or a single-bit write
  function automatic logic [7:0] merge_wr(input logic [7:0] cur,
                                          input logic [7:0] wmask,
                                          input logic       byte_wr,
                                          input logic       bit_wr,
                                          input logic [2:0] bsel,
                                          input logic       bval,
                                          input logic [7:0] wdata);
    logic [7:0] img;
    img = cur;
    if (byte_wr) begin
      img = wdata;
    end else if (bit_wr) begin
      img[bsel] = bval;
    end
    return (img & wmask) | (cur & ~wmask);
  endfunction

  always_comb begin
    nxt_pin_mode = merge_wr(pin_mode_ff, PIN_MODE_WMASK,
                            WR_I && hit_pin, BIT_WR_I && hit_pin,
                            BIT_SEL_I, BIT_VAL_I, WDATA_I);
  end

  always_comb begin
    cpu_ctrl_wr = merge_wr({3'h0, cpu_src_sub_ff, 1'b0, cpu_div_ff},
                           CPU_CLK_WMASK,
                           WR_I && hit_cpu, BIT_WR_I && hit_cpu,
                           BIT_SEL_I, BIT_VAL_I, WDATA_I);
  end

  // ---------------------------------------------------------------
  // clock_pin_mode_select
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      pin_mode_ff <= PIN_MODE_RESET;
    end else if (CE_I) begin
      pin_mode_ff <= nxt_pin_mode;
    end
  end

  // ---------------------------------------------------------------
  // cpu_clock_control
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      cpu_src_sub_ff <= CPU_CLK_RESET[CC_SRC_SUB_POS];
      cpu_div_ff     <= CPU_CLK_RESET[CC_DIV_LSB +: 3];
    end else if (CE_I) begin
      cpu_src_sub_ff <= cpu_ctrl_wr[CC_SRC_SUB_POS];
      cpu_div_ff     <= cpu_ctrl_wr[CC_DIV_LSB +: 3];
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      RDATA_O <= 8'h00;
    end else if (CE_I && RD_I) begin
      if (hit_pin) begin
        RDATA_O <= pin_mode_ff & PIN_MODE_WMASK;
      end else if (hit_cpu) begin
        RDATA_O <= {2'h0, on_sub_ff, cpu_src_sub_ff, 1'b0,
                    cpu_div_ff};
      end else begin
        RDATA_O <= 8'h00;
      end
    end
  end

  // ---------------------------------------------------------------
  // pin modes and oscillator enables
  // ---------------------------------------------------------------
  logic ext_sel;
  logic hs_osc_sel;
  logic crystal_mode;
  logic ext_mode;
  logic ls_stop_ok_ff;

  assign ext_sel      = pin_mode_ff[PM_EXT_SEL_POS];
  assign hs_osc_sel   = pin_mode_ff[PM_HS_OSC_POS];
  assign crystal_mode = hs_osc_sel && !ext_sel;
  assign ext_mode     = hs_osc_sel && ext_sel;

  always_comb begin
    CRYSTAL_IN_PIN_PORT_O   = !crystal_mode;
    CRYSTAL_OUT_PIN_PORT_O  = !hs_osc_sel;
    SUB_CRYSTAL_PINS_PORT_O = !pin_mode_ff[PM_SUB_OSC_POS];
    MAIN_OSC_EN_O   = crystal_mode && !MAIN_OSC_STOP_I
                      && !STOP_MODE_I;
    EXT_CLK_EN_O    = ext_mode && !MAIN_OSC_STOP_I
                      && !STOP_MODE_I;
    HS_INT_OSC_EN_O = !HS_INT_OSC_STOP_I && !STOP_MODE_I;
    // crystal stays up while the cpu still runs on it
    SUB_OSC_EN_O    = pin_mode_ff[PM_SUB_OSC_POS]
                      || on_sub_ff;
    LS_INT_OSC_EN_O = !(LS_INT_OSC_STOP_I && ls_stop_ok_ff);
  end

  // option setting is caught while reset is held
  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      ls_stop_ok_ff <= LS_SW_STOP_ALLOWED_I;
    end
  end

  // ---------------------------------------------------------------
  // gated source ticks
  // ---------------------------------------------------------------
  logic hs_sys_tick;
  logic ih_tick;
  logic sub_tick;
  logic ls_tick;
  logic hs_sys_en;
  logic main_req_hs;
  logic periph_req_hs;

  assign hs_sys_tick = (CRYSTAL_TICK_I && MAIN_OSC_EN_O)
                    || (EXT_CLK_TICK_I && EXT_CLK_EN_O);
  assign hs_sys_en   = MAIN_OSC_EN_O || EXT_CLK_EN_O;
  assign ih_tick     = HIGH_SPEED_INTERNAL_TICK_I && HS_INT_OSC_EN_O;
  assign sub_tick    = SUB_CRYSTAL_TICK_I && SUB_OSC_EN_O;
  assign ls_tick     = LOW_SPEED_INTERNAL_TICK_I && LS_INT_OSC_EN_O;

  assign main_req_hs   = HS_CLOCK_ENABLE_SELECT_I
                         && MAIN_CLOCK_SOURCE_SELECT_I;
  assign periph_req_hs = HS_CLOCK_ENABLE_SELECT_I;

  // ---------------------------------------------------------------
  // active cpu clock selection, switched at a tick boundary or at once when the running source is stopped
  // ---------------------------------------------------------------
  logic       act_main_hs_ff;
  logic [2:0] act_div_ff;
  logic [2:0] req_div;
  logic       cpu_tick;
  logic       src_dead;
  logic       change_req;
  logic       apply_sw;
  logic       div_src_tick;
  logic [2:0] div_shift;
  logic       main_tick;

  // prohibited ratios clamp to the largest one
  assign req_div = cpu_src_sub_ff ? DIV_SUB_CODE
                 : (cpu_div_ff > DIV_MAX_CODE) ? DIV_MAX_CODE
                 : cpu_div_ff;

  assign src_dead = on_sub_ff      ? !SUB_OSC_EN_O
                  : act_main_hs_ff ? !hs_sys_en
                  : !HS_INT_OSC_EN_O;

  assign change_req = (cpu_src_sub_ff != on_sub_ff)
                   || (req_div != act_div_ff)
                   || (main_req_hs != act_main_hs_ff);

  // a switch waits for the end of the running period, unless the running source is stopped
  assign apply_sw = change_req && (cpu_tick || src_dead);

  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      act_main_hs_ff <= 1'b0;
      on_sub_ff      <= CPU_CLK_RESET[CC_SRC_SUB_POS];
      act_div_ff     <= CPU_CLK_RESET[CC_DIV_LSB +: 3];
    end else if (CE_I && apply_sw) begin
      act_main_hs_ff <= main_req_hs;
      on_sub_ff      <= cpu_src_sub_ff;
      act_div_ff     <= req_div;
    end
  end

  assign main_tick    = act_main_hs_ff ? hs_sys_tick : ih_tick;
  assign div_src_tick = on_sub_ff ? sub_tick : main_tick;
  assign div_shift    = act_div_ff;

  cgen_tick_div #(
    .CNT_W   (DIV_CNT_W)
  ) u_cpu_div (
    .clk_i   (CORE_CLK_I),
    .rstn_i  (RSTN_I),
    .ce_i    (CE_I),
    .clr_i   (apply_sw),
    .tick_i  (div_src_tick),
    .shift_i (div_shift),
    .tick_o  (cpu_tick)
  );

  // ---------------------------------------------------------------
  // minimum instruction time
  // ---------------------------------------------------------------
  logic insn_phase_ff;

  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      insn_phase_ff <= 1'b0;
    end else if (CE_I && cpu_tick) begin
      insn_phase_ff <= !insn_phase_ff;
    end
  end

  // ---------------------------------------------------------------
  // registered tick outputs
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      MAIN_TICK_O       <= 1'b0;
      PERIPH_TICK_O     <= 1'b0;
      CPU_TICK_O        <= 1'b0;
      MIN_INSN_TICK_O   <= 1'b0;
      WDT_TICK_O        <= 1'b0;
      TIMER_LS_TICK_O   <= 1'b0;
      DISPLAY_LS_TICK_O <= 1'b0;
    end else if (CE_I) begin
      MAIN_TICK_O       <= main_tick;
      PERIPH_TICK_O     <= periph_req_hs ? hs_sys_tick : ih_tick;
      CPU_TICK_O        <= cpu_tick;
      MIN_INSN_TICK_O   <= cpu_tick && insn_phase_ff;
      WDT_TICK_O        <= ls_tick;
      TIMER_LS_TICK_O   <= ls_tick && TIMER_USES_LS_I;
      DISPLAY_LS_TICK_O <= ls_tick && DISPLAY_USES_LS_I;
    end
  end

  assign CPU_ON_SUB_O = on_sub_ff;

endmodule

// *** cgen_pkg.sv ***
// constants for the system clock generator
package cgen_pkg;

  // ---------------------------------------------------------------
  // register addresses
  // ---------------------------------------------------------------
  localparam logic [15:0] PIN_MODE_ADDR     = 16'hff9f;
  localparam logic [15:0] CPU_CLK_CTRL_ADDR = 16'hfffb;

  // ---------------------------------------------------------------
  // clock_pin_mode_select fields
  // ---------------------------------------------------------------
  localparam int          PM_EXT_SEL_POS  = 7;
  localparam int          PM_HS_OSC_POS   = 6;
  localparam int          PM_SUB_OSC_POS  = 4;
  localparam logic [7:0]  PIN_MODE_RESET  = 8'h00;
  localparam logic [7:0]  PIN_MODE_WMASK  = 8'hd0;

  // ---------------------------------------------------------------
  // cpu_clock_control fields
  // ---------------------------------------------------------------
  localparam int          CC_DIV_LSB      = 0;
  localparam int          CC_SRC_SUB_POS  = 4;
  localparam int          CC_ON_SUB_POS   = 5;
  localparam logic [7:0]  CPU_CLK_RESET   = 8'h01;
  localparam logic [7:0]  CPU_CLK_WMASK   = 8'h17;

  // ---------------------------------------------------------------
  // divide codes (log2 of the ratio)
  // ---------------------------------------------------------------
  localparam logic [2:0]  DIV_MAX_CODE    = 3'h4;
  localparam logic [2:0]  DIV_SUB_CODE    = 3'h1;
  localparam int          MIN_INSN_CLOCKS = 2;

endpackage

// *** cgen_tick_div.sv ***
// divides a stream of source ticks by a power of two
`timescale 1ns/1ps
module cgen_tick_div #(
  parameter int CNT_W = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic             ce_i,
  input  wire logic             clr_i,
  input  wire logic             tick_i,
  input  wire logic [2:0]       shift_i,
  output logic                  tick_o
);

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] last_cnt;

  generate
    if (CNT_W < 4) begin : g_chk
      $error("cgen_tick_div needs CNT_W of at least 4");
    end
  endgenerate

  // terminal count for the chosen ratio
  always_comb begin
    last_cnt = CNT_W'((1 << shift_i) - 1);
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt_ff <= '0;
    end else if (ce_i) begin
      if (clr_i) begin
        cnt_ff <= '0;
      end else if (tick_i) begin
        if (cnt_ff >= last_cnt) begin
          cnt_ff <= '0;
        end else begin
          cnt_ff <= cnt_ff + CNT_W'(1);
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      tick_o <= 1'b0;
    end else if (ce_i) begin
      tick_o <= !clr_i && tick_i && (cnt_ff >= last_cnt);
    end
  end

endmodule

// *** cgen_clock_gen_checker.sv ***
// port assertions for the system clock generator
`timescale 1ns/1ps
module cgen_clock_gen_checker
  import cgen_pkg::*;
(
  input wire logic        CORE_CLK_I,
  input wire logic        RSTN_I,
  input wire logic        CE_I,
  input wire logic [15:0] ADDR_I,
  input wire logic        WR_I,
  input wire logic [7:0]  WDATA_I,
  input wire logic        STOP_MODE_I,
  input wire logic        MAIN_OSC_STOP_I,
  input wire logic        HS_INT_OSC_STOP_I,
  input wire logic        LS_INT_OSC_STOP_I,
  input wire logic        LOW_SPEED_INTERNAL_TICK_I,
  input wire logic        MAIN_OSC_EN_O,
  input wire logic        EXT_CLK_EN_O,
  input wire logic        HS_INT_OSC_EN_O,
  input wire logic        LS_INT_OSC_EN_O,
  input wire logic        CRYSTAL_IN_PIN_PORT_O,
  input wire logic        CRYSTAL_OUT_PIN_PORT_O,
  input wire logic        SUB_CRYSTAL_PINS_PORT_O,
  input wire logic        CPU_TICK_O,
  input wire logic        MIN_INSN_TICK_O,
  input wire logic        WDT_TICK_O
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  logic [7:0] wd_ff;

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);

  // write data of the previous cycle, for the pin decode checks
  always_ff @(posedge CORE_CLK_I) begin
    wd_ff <= WDATA_I;
  end

  sequence pm_wr;
    CE_I && WR_I && ADDR_I == PIN_MODE_ADDR;
  endsequence

  stop_all_a:
    assert property (STOP_MODE_I |-> !MAIN_OSC_EN_O && !EXT_CLK_EN_O
      && !HS_INT_OSC_EN_O) else $error("source runs in stop mode");
  main_stop_a:
    assert property (MAIN_OSC_STOP_I |-> !MAIN_OSC_EN_O && !EXT_CLK_EN_O)
      else $error("main source runs while stopped");
  hs_stop_a:
    assert property (HS_INT_OSC_STOP_I |-> !HS_INT_OSC_EN_O)
      else $error("internal fast oscillator runs while stopped");
  ls_run_a:
    assert property (!LS_INT_OSC_STOP_I |-> LS_INT_OSC_EN_O)
      else $error("low speed oscillator stopped without request");
  pin_decode_a:
    assert property (pm_wr |=> CRYSTAL_OUT_PIN_PORT_O == !wd_ff[6]
      && CRYSTAL_IN_PIN_PORT_O == (wd_ff[7] || !wd_ff[6]))
      else $error("fast pin mode decode wrong");
  sub_pin_a:
    assert property (pm_wr |=> SUB_CRYSTAL_PINS_PORT_O == !wd_ff[4])
      else $error("sub pin mode decode wrong");
  wdt_src_a:
    assert property (WDT_TICK_O |-> $past(LOW_SPEED_INTERNAL_TICK_I))
      else $error("watchdog tick without low speed tick");
  insn_pair_a:
    assert property (MIN_INSN_TICK_O |-> CPU_TICK_O
      ##1 (!MIN_INSN_TICK_O || !$past(CE_I)))
      else $error("instruction tick off the cpu tick");
endmodule

bind cgen_clock_gen cgen_clock_gen_checker chk_i (.*);

// *** cgen_clock_gen_bench.sv ***
// self-checking bench for the system clock generator
`timescale 1ns/1ps
module cgen_clock_gen_bench;
  import cgen_pkg::*;
  logic CORE_CLK_I = 0, RSTN_I = 0, CE_I = 1, WR_I = 0, RD_I = 0;
  logic BIT_WR_I = 0, BIT_VAL_I = 0, STOP_MODE_I = 0, ph = 0;
  logic MAIN_OSC_STOP_I = 1, HS_INT_OSC_STOP_I = 0;
  logic LS_INT_OSC_STOP_I = 0, LS_SW_STOP_ALLOWED_I = 0;
  logic HS_CLOCK_ENABLE_SELECT_I = 0, MAIN_CLOCK_SOURCE_SELECT_I = 0;
  logic TIMER_USES_LS_I = 0, DISPLAY_USES_LS_I = 1;
  logic [15:0] ADDR_I = 16'h0000;
  logic [7:0]  WDATA_I = 8'h00, RDATA_O, rv;
  logic [2:0]  BIT_SEL_I = 3'h0;
  logic [4:0]  src = 5'h04;
  logic MAIN_OSC_EN_O, EXT_CLK_EN_O, HS_INT_OSC_EN_O, SUB_OSC_EN_O;
  logic LS_INT_OSC_EN_O, CRYSTAL_IN_PIN_PORT_O, CRYSTAL_OUT_PIN_PORT_O;
  logic SUB_CRYSTAL_PINS_PORT_O, MAIN_TICK_O, PERIPH_TICK_O, CPU_TICK_O;
  logic MIN_INSN_TICK_O, CPU_ON_SUB_O, WDT_TICK_O, TIMER_LS_TICK_O;
  logic DISPLAY_LS_TICK_O;
  int n_mismatch = 0, checks = 0, p;
  // source ticks every other cycle, each gated by its bit of src
  wire CRYSTAL_TICK_I = ph & src[0];
  wire EXT_CLK_TICK_I = ph & src[1];
  wire HIGH_SPEED_INTERNAL_TICK_I = ph & src[2];
  wire SUB_CRYSTAL_TICK_I = ph & src[3];
  wire LOW_SPEED_INTERNAL_TICK_I = ph & src[4];

  cgen_clock_gen uut (.*);

  initial begin
    forever #4 CORE_CLK_I = ~CORE_CLK_I;
  end
  always @(negedge CORE_CLK_I) ph <= ~ph;

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic complete_run();
    if (n_mismatch == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic do_reset(input logic allow);
    @(negedge CORE_CLK_I);
    RSTN_I = 0;
    LS_SW_STOP_ALLOWED_I = allow;
    repeat (3) @(negedge CORE_CLK_I);
    RSTN_I = 1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge CORE_CLK_I);
    ADDR_I = a;
    WDATA_I = d;
    WR_I = 1;
    @(negedge CORE_CLK_I);
    WR_I = 0;
  endtask
  task automatic bw(input logic [15:0] a, input logic [2:0] b, input logic v);
    @(negedge CORE_CLK_I);
    ADDR_I = a;
    BIT_SEL_I = b;
    BIT_VAL_I = v;
    BIT_WR_I = 1;
    @(negedge CORE_CLK_I);
    BIT_WR_I = 0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge CORE_CLK_I);
    ADDR_I = a;
    RD_I = 1;
    @(negedge CORE_CLK_I);
    RD_I = 0;
    @(negedge CORE_CLK_I);
    d = RDATA_O;
  endtask
  // cycles between two pulses of the cpu tick, or the insn tick if m
  task automatic per(input bit m, output int c);
    int k, s;
    s = -1;
    repeat (70) @(negedge CORE_CLK_I);
    for (k = 0; k < 300; k++) begin
      @(negedge CORE_CLK_I);
      if ((m ? MIN_INSN_TICK_O : CPU_TICK_O) === 1'b1) begin
        if (s >= 0) begin
          c = k - s;
          return;
        end
        s = k;
      end
    end
    n_mismatch++;
    complete_run();
  endtask
  // main and peripheral tick pulses seen over 20 cycles
  task automatic cnt(output int m, q);
    m = 0;
    q = 0;
    repeat (20) begin
      @(negedge CORE_CLK_I);
      m += (MAIN_TICK_O === 1'b1);
      q += (PERIPH_TICK_O === 1'b1);
    end
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rd(PIN_MODE_ADDR, rv);
    chk("pin mode", PIN_MODE_RESET, rv);
    rd(CPU_CLK_CTRL_ADDR, rv);
    chk("cpu ctrl", CPU_CLK_RESET, rv);
    // a write while the clock enable is low must be lost
    CE_I = 0;
    wr(CPU_CLK_CTRL_ADDR, 8'h03);
    CE_I = 1;
    rd(CPU_CLK_CTRL_ADDR, rv);
    chk("frozen write", CPU_CLK_RESET, rv);
    rv = {5'h00, CRYSTAL_IN_PIN_PORT_O, CRYSTAL_OUT_PIN_PORT_O,
          SUB_CRYSTAL_PINS_PORT_O};
    chk("pin ports", 8'h07, rv);
    chk("on sub", 8'h00, {7'h00, CPU_ON_SUB_O});
    per(0, p);
    chk("reset period", 8'h04, 8'(p));
    rd(16'h1234, rv);
    chk("unmapped", 8'h00, rv);
  endtask
  task automatic t_div();
    // code 5 is prohibited and clamps to the largest ratio
    for (int c = 0; c < 6; c++) begin
      wr(CPU_CLK_CTRL_ADDR, 8'(c));
      per(0, p);
      chk("cpu period", 8'(2 << ((c > 4) ? 4 : c)), 8'(p));
      per(1, p);
      chk("insn period", 8'(4 << ((c > 4) ? 4 : c)), 8'(p));
    end
    wr(CPU_CLK_CTRL_ADDR, 8'hea);
    bw(CPU_CLK_CTRL_ADDR, 3'h5, 1'b1);
    rd(CPU_CLK_CTRL_ADDR, rv);
    chk("cpu ctrl bits", 8'h02, rv);
  endtask
  task automatic t_main();
    int m, q;
    for (int i = 0; i < 4; i++) begin
      wr(PIN_MODE_ADDR, {2'(i), 6'h00});
      rv = {6'h00, CRYSTAL_IN_PIN_PORT_O, CRYSTAL_OUT_PIN_PORT_O};
      chk("fast pins", (i == 1) ? 8'h00 : (i == 3) ? 8'h02 : 8'h03, rv);
    end
    wr(PIN_MODE_ADDR, 8'h40);
    MAIN_OSC_STOP_I = 0;
    HS_CLOCK_ENABLE_SELECT_I = 1;
    MAIN_CLOCK_SOURCE_SELECT_I = 1;
    // internal oscillator keeps ticking so the pending switch can land
    src = 5'h05;
    wr(CPU_CLK_CTRL_ADDR, 8'h01);
    chk("crystal on", 8'h01, {7'h00, MAIN_OSC_EN_O});
    per(0, p);
    chk("crystal period", 8'h04, 8'(p));
    src = 5'h01;
    cnt(m, q);
    chk("main crystal", 8'd10, 8'(m));
    chk("periph crystal", 8'd10, 8'(q));
    MAIN_OSC_STOP_I = 1;
    wr(PIN_MODE_ADDR, 8'hc0);
    MAIN_OSC_STOP_I = 0;
    src = 5'h02;
    per(0, p);
    chk("external period", 8'h04, 8'(p));
    chk("external on", 8'h01, {7'h00, EXT_CLK_EN_O});
    STOP_MODE_I = 1;
    @(negedge CORE_CLK_I);
    chk("external stop", 8'h00, {7'h00, EXT_CLK_EN_O});
    STOP_MODE_I = 0;
    // main back on internal, peripherals stay on the fast system clock
    MAIN_CLOCK_SOURCE_SELECT_I = 0;
    src = 5'h06;
    per(0, p);
    chk("internal period", 8'h04, 8'(p));
    src = 5'h04;
    cnt(m, q);
    chk("main internal", 8'd10, 8'(m));
    chk("periph fast", 8'd0, 8'(q));
    MAIN_OSC_STOP_I = 1;
    HS_CLOCK_ENABLE_SELECT_I = 0;
    src = 5'h04;
    wr(PIN_MODE_ADDR, 8'h00);
  endtask
  task automatic t_sub();
    bw(PIN_MODE_ADDR, 3'h4, 1'b1);
    chk("sub pins", 8'h00, {7'h00, SUB_CRYSTAL_PINS_PORT_O});
    chk("sub osc", 8'h01, {7'h00, SUB_OSC_EN_O});
    src = 5'h0c;
    for (int c = 0; c < 5; c++) begin
      wr(CPU_CLK_CTRL_ADDR, 8'(16 + c));
      per(0, p);
      chk("sub period", 8'h04, 8'(p));
    end
    rd(CPU_CLK_CTRL_ADDR, rv);
    chk("sub status", 8'h34, rv);
    wr(CPU_CLK_CTRL_ADDR, 8'h00);
    per(0, p);
    chk("back to main", 8'h02, 8'(p));
    chk("off sub", 8'h00, {7'h00, CPU_ON_SUB_O});
  endtask
  task automatic t_ls();
    int w, d, t;
    src = 5'h14;
    // second pass swaps which consumer selects the low-speed clock
    for (int k = 0; k < 2; k++) begin
      w = 0;
      d = 0;
      t = 0;
      repeat (20) begin
        @(negedge CORE_CLK_I);
        w += (WDT_TICK_O === 1'b1);
        d += (DISPLAY_LS_TICK_O === 1'b1);
        t += (TIMER_LS_TICK_O === 1'b1);
      end
      chk("wdt ticks", 8'd10, 8'(w));
      chk("display ticks", (k == 0) ? 8'd10 : 8'd0, 8'(d));
      chk("timer ticks", (k == 0) ? 8'd0 : 8'd10, 8'(t));
      TIMER_USES_LS_I = 1;
      DISPLAY_USES_LS_I = 0;
    end
    LS_INT_OSC_STOP_I = 1;
    HS_INT_OSC_STOP_I = 1;
    @(negedge CORE_CLK_I);
    chk("ls kept", 8'h01, {7'h00, LS_INT_OSC_EN_O});
    chk("hs stop", 8'h00, {7'h00, HS_INT_OSC_EN_O});
    HS_INT_OSC_STOP_I = 0;
    do_reset(1'b1);
    @(negedge CORE_CLK_I);
    chk("ls stop", 8'h00, {7'h00, LS_INT_OSC_EN_O});
    LS_INT_OSC_STOP_I = 0;
    @(negedge CORE_CLK_I);
    chk("ls run", 8'h01, {7'h00, LS_INT_OSC_EN_O});
  endtask

  initial begin
    do_reset(1'b0);
    t_reset();
    t_div();
    t_main();
    t_sub();
    t_ls();
    complete_run();
  end
endmodule
